// >>> core/dws_pkg.sv
// Shared constants, types and burst decode for the write sequencing link.
package dws_pkg;
  localparam int BG_W       = 2;
  localparam int BA_W       = 2;
  localparam int COL_W      = 10;
  localparam int ADDR_W     = 14;
  localparam int DQ_W       = 8;
  localparam int LAT_W      = 5;
  localparam int WL_W       = 6;
  localparam int DLY_DEPTH  = 64;
  localparam int BURST_W    = 64;
  localparam int A10_POS    = 10;
  localparam int A12_POS    = 12;
  localparam logic [1:0] BL_FIX8  = 2'h0;
  localparam logic [1:0] BL_OTF   = 2'h1;
  localparam logic [1:0] BL_FIX4  = 2'h2;
  localparam logic [1:0] MR0_BL_RST = 2'h0;
  localparam logic [LAT_W-1:0] AL_RST  = 5'h00;
  localparam logic [LAT_W-1:0] CWL_RST = 5'h0a;
  localparam logic [LAT_W-1:0] CWL_MIN = 5'h09;
  localparam logic [1:0] CLK_BL8  = 2'h3;
  localparam logic [1:0] CLK_BC4  = 2'h1;
  localparam logic [2:0] GAP_MAX  = 3'h7;
  localparam logic [2:0] CCD_DIFF = 3'h4;
  localparam logic [2:0] CCD_SAME = 3'h5;
  localparam logic [2:0] CCD_BAD2 = 3'h5;
  localparam logic [2:0] CCD_PRE2 = 3'h6;

  typedef struct packed {
    logic             vld;
    logic             bc4;
    logic             ap;
    logic [BG_W-1:0]  bg;
    logic [BA_W-1:0]  ba;
    logic [COL_W-1:0] col;
  } dws_cmd_t;

  typedef struct packed {
    logic               vld;
    logic               bc4;
    logic [BURST_W-1:0] data;
  } dws_pay_t;

  function automatic logic dws_is_bc4(input logic [1:0] bl, input logic a12);
    dws_is_bc4 = (bl == BL_FIX4) || ((bl == BL_OTF) && !a12);
  endfunction

  function automatic logic dws_gap_ok(input logic [2:0] sp, input logic same_bg,
                                      input logic pre2);
    if (pre2) begin
      dws_gap_ok = (sp >= CCD_PRE2) || (!same_bg && (sp == CCD_DIFF));
    end else begin
      dws_gap_ok = (sp >= CCD_SAME) || (!same_bg && (sp == CCD_DIFF));
    end
  endfunction
endpackage

// >>> core/dws_link_if.sv
// Link between the write controller and the memory device.
`timescale 1ns/1ps
`default_nettype none
interface dws_link_if;
  import dws_pkg::*;
  logic [1:0]        mr0_bl;
  logic [LAT_W-1:0]  al;
  logic [LAT_W-1:0]  cwl;
  logic              pre2;
  logic              cmd_wr;
  logic [BG_W-1:0]   bg;
  logic [BA_W-1:0]   ba;
  logic [ADDR_W-1:0] addr;
  logic              dq_en;
  logic [DQ_W-1:0]   dq_rise;
  logic [DQ_W-1:0]   dq_fall;

  modport ctrl (output mr0_bl, al, cwl, pre2, cmd_wr, bg, ba, addr, dq_en, dq_rise, dq_fall);
  modport dram (input mr0_bl, al, cwl, pre2, cmd_wr, bg, ba, addr, dq_en, dq_rise, dq_fall);
endinterface
`default_nettype wire

// >>> core/dws_dram.sv
// Device end: decodes each write, times its data window and captures the burst.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// R1: Fixed, or on-the-fly with A12 high, gives BL8.
// R2: On-the-fly with A12 low gives burst chop.
// R3: Fixed chop mode chops every write.
// R4: Two-clock preamble needs CWL above minimum.
// R5: Two-clock preamble forbids five-clock write spacing.
// R6: Recovery counts from edge after last beat.
// R7: Four-clock spacing across bank groups is legal.
// R8: Five-clock spacing legal in any bank group with the one-clock preamble.
// R9: Burst length decided anew for every write.
// R10: First data arrives AL plus CWL after command.
// R11: A10 high selects auto precharge.
// R12: Chopped bursts keep only first four beats.
module dws_dram (
  input  wire logic                        clk_sys,
  input  wire logic                        reset,
  input  wire logic                        ce,
  dws_link_if.dram                         link,
  output var  logic                        wr_done,
  output var  logic                        wr_bc4,
  output var  logic                        wr_autopre,
  output var  logic [dws_pkg::BG_W-1:0]    wr_bg,
  output var  logic [dws_pkg::BA_W-1:0]    wr_ba,
  output var  logic [dws_pkg::COL_W-1:0]   wr_col,
  output var  logic [dws_pkg::BURST_W-1:0] wr_data,
  output var  logic                        spacing_err
);
  import dws_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Command decode and latency line.

  dws_cmd_t          dly_r [DLY_DEPTH];
  dws_cmd_t          dly_nxt [DLY_DEPTH];
  dws_cmd_t          new_cmd;
  logic [WL_W-1:0]   wl;
  logic [WL_W-1:0]   tap;
  dws_cmd_t          due;
  logic [2:0]        gap_r;
  logic [2:0]        gap_nxt;
  logic [BG_W-1:0]   last_bg_r;
  logic [BG_W-1:0]   last_bg_nxt;
  logic              seen_r;
  logic              seen_nxt;
  logic              err_r;
  logic              err_nxt;

  always_comb begin
    new_cmd     = '0;
    new_cmd.vld = link.cmd_wr;
    new_cmd.bc4 = dws_is_bc4(link.mr0_bl, link.addr[A12_POS]); // see R1 R2 R3 R9
    new_cmd.ap  = link.addr[A10_POS]; // see R11
    new_cmd.bg  = link.bg;
    new_cmd.ba  = link.ba;
    new_cmd.col = link.addr[COL_W-1:0];
    dly_nxt[0]  = new_cmd;
    for (int i = 1; i < DLY_DEPTH; i++) begin
      dly_nxt[i] = dly_r[i-1];
    end
    wl  = WL_W'(link.al) + WL_W'(link.cwl); // see R10
    tap = wl - WL_W'(1);
    due = (wl != '0) ? dly_r[tap] : '0;
  end

  // The checker only flags; the burst is still captured so one bad command
  // does not desynchronise every later one.
  always_comb begin
    gap_nxt     = (gap_r == GAP_MAX) ? gap_r : gap_r + 3'h1;
    last_bg_nxt = last_bg_r;
    seen_nxt    = seen_r;
    err_nxt     = err_r;
    if (link.cmd_wr) begin
      if (seen_r && !dws_gap_ok(gap_r, link.bg == last_bg_r, link.pre2)) begin
        err_nxt = 1'b1; // see R5 R7 R8
      end
      if (link.pre2 && (link.cwl <= CWL_MIN)) begin
        err_nxt = 1'b1; // see R4
      end
      gap_nxt     = 3'h1;
      last_bg_nxt = link.bg;
      seen_nxt    = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      for (int i = 0; i < DLY_DEPTH; i++) begin
        dly_r[i] <= '0;
      end
      gap_r     <= GAP_MAX;
      last_bg_r <= '0;
      seen_r    <= 1'b0;
      err_r     <= 1'b0;
    end else if (ce) begin
      dly_r     <= dly_nxt;
      gap_r     <= gap_nxt;
      last_bg_r <= last_bg_nxt;
      seen_r    <= seen_nxt;
      err_r     <= err_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Burst capture.

  logic               act_r;
  logic               act_nxt;
  logic [1:0]         cnt_r;
  logic [1:0]         cnt_nxt;
  logic [1:0]         last_r;
  logic [1:0]         last_nxt;
  dws_cmd_t           cur_r;
  dws_cmd_t           cur_nxt;
  logic [BURST_W-1:0] buf_r;
  logic [BURST_W-1:0] buf_nxt;
  logic               done_nxt;
  logic [BURST_W-1:0] data_nxt;
  dws_cmd_t           out_nxt;
  logic [1:0]         slot;
  logic               take;
  logic               wr_bc4_nxt;
  logic               wr_autopre_nxt;
  logic [BG_W-1:0]    wr_bg_nxt;
  logic [BA_W-1:0]    wr_ba_nxt;
  logic [COL_W-1:0]   wr_col_nxt;

  always_comb begin
    act_nxt  = act_r;
    cnt_nxt  = cnt_r;
    last_nxt = last_r;
    cur_nxt  = cur_r;
    buf_nxt  = buf_r;
    done_nxt = 1'b0;
    data_nxt = wr_data;
    out_nxt  = cur_r;
    slot     = cnt_r;
    take     = act_r;
    wr_bc4_nxt     = wr_bc4;
    wr_autopre_nxt = wr_autopre;
    wr_bg_nxt      = wr_bg;
    wr_ba_nxt      = wr_ba;
    wr_col_nxt     = wr_col;
    if (due.vld) begin
      // A due command starts a new burst at once, dropping any burst still being captured.
      cur_nxt  = due;
      buf_nxt  = '0;
      last_nxt = due.bc4 ? CLK_BC4 : CLK_BL8; // see R12
      slot     = 2'h0;
      take     = 1'b1;
      out_nxt  = due;
    end
    if (take) begin
      buf_nxt[slot*16 +: 16] = {link.dq_fall, link.dq_rise};
      if (slot == last_nxt) begin
        act_nxt  = 1'b0;
        done_nxt = 1'b1; // see R6
        data_nxt = buf_nxt;
        wr_bc4_nxt     = out_nxt.bc4;
        wr_autopre_nxt = out_nxt.ap; // see R11
        wr_bg_nxt      = out_nxt.bg;
        wr_ba_nxt      = out_nxt.ba;
        wr_col_nxt     = out_nxt.col;
      end else begin
        act_nxt = 1'b1;
        cnt_nxt = slot + 2'h1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      act_r       <= 1'b0;
      cnt_r       <= '0;
      last_r      <= '0;
      cur_r       <= '0;
      buf_r       <= '0;
      wr_done     <= 1'b0;
      wr_bc4      <= 1'b0;
      wr_autopre  <= 1'b0;
      wr_bg       <= '0;
      wr_ba       <= '0;
      wr_col      <= '0;
      wr_data     <= '0;
      spacing_err <= 1'b0;
    end else if (ce) begin
      act_r       <= act_nxt;
      cnt_r       <= cnt_nxt;
      last_r      <= last_nxt;
      cur_r       <= cur_nxt;
      buf_r       <= buf_nxt;
      wr_done     <= done_nxt;
      spacing_err <= err_nxt;
      wr_bc4      <= wr_bc4_nxt;
      wr_autopre  <= wr_autopre_nxt;
      wr_bg       <= wr_bg_nxt;
      wr_ba       <= wr_ba_nxt;
      wr_col      <= wr_col_nxt;
      wr_data     <= data_nxt;
    end
  end
endmodule
`default_nettype wire

// >>> core/dws_ctrl.sv
// Controller end: spaces write commands and drives each burst at write latency.
`timescale 1ns/1ps
`default_nettype none
module dws_ctrl (
  input  wire logic                        clk_sys,
  input  wire logic                        reset,
  input  wire logic                        ce,
  dws_link_if.ctrl                         link,
  input  wire logic [1:0]                  cfg_bl,
  input  wire logic [dws_pkg::LAT_W-1:0]   cfg_al,
  input  wire logic [dws_pkg::LAT_W-1:0]   cfg_cwl,
  input  wire logic                        cfg_pre2,
  input  wire logic                        req_valid,
  output var  logic                        req_ready,
  input  wire logic [dws_pkg::BG_W-1:0]    req_bg,
  input  wire logic [dws_pkg::BA_W-1:0]    req_ba,
  input  wire logic [dws_pkg::COL_W-1:0]   req_col,
  input  wire logic                        req_a12,
  input  wire logic                        req_a10,
  input  wire logic [dws_pkg::BURST_W-1:0] req_data,
  output var  logic                        cfg_err,
  output var  logic                        recov_start
);
  import dws_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Request holding and command spacing.

  logic                 hold_r;
  logic                 hold_nxt;
  logic [BG_W-1:0]      h_bg_r;
  logic [BA_W-1:0]      h_ba_r;
  logic [ADDR_W-1:0]    h_addr_r;
  logic [BURST_W-1:0]   h_data_r;
  logic [2:0]           gap_r;
  logic [2:0]           gap_nxt;
  logic [2:0]           sp;
  logic                 seen_r;
  logic                 issue;
  logic                 bad_cfg;
  logic [ADDR_W-1:0]    req_addr;
  logic                 seen_nxt;
  logic [BG_W-1:0]      h_bg_nxt;
  logic [BA_W-1:0]      h_ba_nxt;
  logic [ADDR_W-1:0]    h_addr_nxt;
  logic [BURST_W-1:0]   h_data_nxt;
  logic [BG_W-1:0]      cmd_bg_nxt;
  logic [BA_W-1:0]      cmd_ba_nxt;
  logic [ADDR_W-1:0]    cmd_addr_nxt;

  always_comb begin
    req_addr             = '0;
    req_addr[COL_W-1:0]  = req_col;
    req_addr[A10_POS]    = req_a10;
    req_addr[A12_POS]    = req_a12;
    sp       = (gap_r == GAP_MAX) ? gap_r : gap_r + 3'h1;
    bad_cfg  = cfg_pre2 && (cfg_cwl <= CWL_MIN); // see R4
    issue    = hold_r && !bad_cfg &&
               (!seen_r || dws_gap_ok(sp, h_bg_r == link.bg, cfg_pre2)); // see R5 R7 R8
    gap_nxt  = issue ? 3'h0 : sp;
    hold_nxt = (hold_r && !issue) || (req_valid && req_ready);
    seen_nxt     = seen_r || issue;
    h_bg_nxt     = h_bg_r;
    h_ba_nxt     = h_ba_r;
    h_addr_nxt   = h_addr_r;
    h_data_nxt   = h_data_r;
    cmd_bg_nxt   = link.bg;
    cmd_ba_nxt   = link.ba;
    cmd_addr_nxt = link.addr;
    if (req_valid && req_ready) begin
      h_bg_nxt   = req_bg;
      h_ba_nxt   = req_ba;
      h_addr_nxt = req_addr;
      h_data_nxt = req_data;
    end
    if (issue) begin
      cmd_bg_nxt   = h_bg_r;
      cmd_ba_nxt   = h_ba_r;
      cmd_addr_nxt = h_addr_r;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      hold_r      <= 1'b0;
      h_bg_r      <= '0;
      h_ba_r      <= '0;
      h_addr_r    <= '0;
      h_data_r    <= '0;
      gap_r       <= GAP_MAX;
      seen_r      <= 1'b0;
      req_ready   <= 1'b0;
      cfg_err     <= 1'b0;
      link.cmd_wr <= 1'b0;
      link.bg     <= '0;
      link.ba     <= '0;
      link.addr   <= '0;
      link.mr0_bl <= MR0_BL_RST;
      link.al     <= AL_RST;
      link.cwl    <= CWL_RST;
      link.pre2   <= 1'b0;
    end else if (ce) begin
      hold_r      <= hold_nxt;
      gap_r       <= gap_nxt;
      req_ready   <= !hold_nxt;
      cfg_err     <= bad_cfg;
      link.cmd_wr <= issue;
      link.mr0_bl <= cfg_bl;
      link.al     <= cfg_al;
      link.cwl    <= cfg_cwl;
      link.pre2   <= cfg_pre2;
      seen_r      <= seen_nxt;
      h_bg_r      <= h_bg_nxt;
      h_ba_r      <= h_ba_nxt;
      h_addr_r    <= h_addr_nxt;
      h_data_r    <= h_data_nxt;
      link.bg     <= cmd_bg_nxt;
      link.ba     <= cmd_ba_nxt;
      link.addr   <= cmd_addr_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data latency line and burst drive.

  dws_pay_t           dly_r [DLY_DEPTH];
  dws_pay_t           dly_nxt [DLY_DEPTH];
  dws_pay_t           pend_r;
  dws_pay_t           pend_nxt;
  logic [WL_W-1:0]    wl;
  dws_pay_t           due;
  logic [BURST_W-1:0] bur_r;
  logic [BURST_W-1:0] bur_nxt;
  logic [1:0]         left_r;
  logic [1:0]         left_nxt;
  logic               en_nxt;
  logic [15:0]        pair;
  logic               end_nxt;

  // The payload is parked beside the command so it enters the line together
  // with the command cycle on the link.
  always_comb begin
    dly_nxt[0]     = '0;
    dly_nxt[0].vld = link.cmd_wr;
    dly_nxt[0].bc4 = dws_is_bc4(link.mr0_bl, link.addr[A12_POS]); // see R1 R2 R3
    dly_nxt[0].data = pend_r.data;
    for (int i = 1; i < DLY_DEPTH; i++) begin
      dly_nxt[i] = dly_r[i-1];
    end
    wl       = WL_W'(link.al) + WL_W'(link.cwl); // see R10
    due      = (wl >= WL_W'(2)) ? dly_r[wl - WL_W'(2)] : '0;
    bur_nxt  = bur_r;
    left_nxt = left_r;
    en_nxt   = 1'b0;
    pair     = '0;
    end_nxt  = link.dq_en && (left_r == 2'h0) && !due.vld;
    // Shifting the burst down serves the chopped and the full length alike.
    if (due.vld) begin
      pair     = due.data[15:0];
      bur_nxt  = due.data >> 16;
      left_nxt = due.bc4 ? CLK_BC4 : CLK_BL8; // see R12
      en_nxt   = 1'b1;
    end else if (link.dq_en && (left_r != 2'h0)) begin
      pair     = bur_r[15:0];
      bur_nxt  = bur_r >> 16;
      left_nxt = left_r - 2'h1;
      en_nxt   = 1'b1;
    end
    pend_nxt = pend_r;
    if (issue) begin
      pend_nxt.data = h_data_r;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      for (int i = 0; i < DLY_DEPTH; i++) begin
        dly_r[i] <= '0;
      end
      pend_r       <= '0;
      bur_r        <= '0;
      left_r       <= '0;
      link.dq_en   <= 1'b0;
      link.dq_rise <= '0;
      link.dq_fall <= '0;
      recov_start  <= 1'b0;
    end else if (ce) begin
      dly_r        <= dly_nxt;
      bur_r        <= bur_nxt;
      left_r       <= left_nxt;
      link.dq_en   <= en_nxt;
      link.dq_rise <= pair[7:0];
      link.dq_fall <= pair[15:8];
      recov_start  <= end_nxt; // see R6
      pend_r       <= pend_nxt;
    end
  end
endmodule
`default_nettype wire

// >>> verif/dws_link_monitor.sv
// Checker for command spacing and data timing on the write link.
`timescale 1ns/1ps
`default_nettype none
module dws_link_monitor (
  input wire logic                       clk_sys,
  input wire logic                       reset,
  input wire logic [1:0]                 mr0_bl,
  input wire logic [dws_pkg::LAT_W-1:0]  al,
  input wire logic [dws_pkg::LAT_W-1:0]  cwl,
  input wire logic                       pre2,
  input wire logic                       cmd_wr,
  input wire logic [dws_pkg::BG_W-1:0]   bg,
  input wire logic [dws_pkg::ADDR_W-1:0] addr,
  input wire logic                       dq_en
);
  import dws_pkg::*;
  //////////////////////////////////////////////////
  // One bit per past cycle, so the data window can be found for any latency from 1 to 62.
  logic [DLY_DEPTH-1:0] hist_r, hist_nxt, chop_r, chop_nxt, fix_r, fix_nxt;
  logic [WL_W-1:0]      wl_m1;
  always_comb begin
    hist_nxt = {hist_r[DLY_DEPTH-2:0], cmd_wr};
    chop_nxt = {chop_r[DLY_DEPTH-2:0], (mr0_bl == 2'h2) || (mr0_bl == 2'h1 && !addr[12])};
    fix_nxt  = {fix_r[DLY_DEPTH-2:0], mr0_bl == 2'h2};
    wl_m1    = {1'b0, al} + {1'b0, cwl} - 6'h01;
  end
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      hist_r <= '0;
      chop_r <= '0;
      fix_r  <= '0;
    end else begin
      hist_r <= hist_nxt;
      chop_r <= chop_nxt;
      fix_r  <= fix_nxt;
    end
  end
  //////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  property p_cwl_pre2; cmd_wr && pre2 |-> cwl > CWL_MIN; endproperty
  a_cwl_pre2: assert property (p_cwl_pre2) else $error("cwl too low");
  property p_gap_min; cmd_wr |=> !cmd_wr [*3]; endproperty
  a_gap_min: assert property (p_gap_min) else $error("writes too close");
  property p_gap_pre2; cmd_wr && pre2 |-> ##5 !cmd_wr; endproperty
  a_gap_pre2: assert property (p_gap_pre2) else $error("five clock gap");
  property p_gap_same; cmd_wr |-> ##4 !(cmd_wr && bg == $past(bg, 4)); endproperty
  a_gap_same: assert property (p_gap_same) else $error("same group gap");
  property p_first; hist_r[wl_m1] |-> dq_en; endproperty
  a_first: assert property (p_first) else $error("data late");
  property p_stray; $rose(dq_en) |-> hist_r[wl_m1]; endproperty
  a_stray: assert property (p_stray) else $error("data early");
  property p_bl8; hist_r[wl_m1] && !chop_r[wl_m1] |-> dq_en [*4]; endproperty
  a_bl8: assert property (p_bl8) else $error("long burst cut");
  property p_bc4; hist_r[wl_m1] && chop_r[wl_m1] |-> dq_en [*2] ##1 !dq_en; endproperty
  a_bc4: assert property (p_bc4) else $error("chop length");
  property p_fix4; hist_r[wl_m1] && fix_r[wl_m1] |-> ##2 !dq_en; endproperty
  a_fix4: assert property (p_fix4) else $error("fixed chop length");
endmodule
`default_nettype wire

// >>> verif/testbench.sv
// Bench joining the write controller and the device over the link.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import dws_pkg::*;
  logic               clk_sys, reset, ce, cfg_pre2, req_valid, req_a12, req_a10;
  logic [1:0]         cfg_bl;
  logic [BG_W-1:0]    req_bg, wr_bg;
  logic [BA_W-1:0]    req_ba, wr_ba;
  logic [LAT_W-1:0]   cfg_al, cfg_cwl;
  logic [COL_W-1:0]   req_col, wr_col;
  logic [BURST_W-1:0] req_data, wr_data;
  logic               req_ready, cfg_err, recov_start, wr_done, wr_bc4, wr_autopre;
  logic               spacing_err;
  int                 bad_count = 0, n_checks = 0, cyc = 0, last = 0, gap = 0;
  int                 lat_q[$], cmd_q[$];
  logic [79:0]        got_q[$];
  //////////////////////////////////////////////////
  dws_link_if i_dws_link_if ();
  dws_ctrl i_dws_ctrl (.clk_sys, .reset, .ce, .link(i_dws_link_if.ctrl), .cfg_bl, .cfg_al,
    .cfg_cwl, .cfg_pre2, .req_valid, .req_ready, .req_bg, .req_ba, .req_col, .req_a12,
    .req_a10, .req_data, .cfg_err, .recov_start);
  dws_dram i_dws_dram (.clk_sys, .reset, .ce, .link(i_dws_link_if.dram), .wr_done, .wr_bc4,
    .wr_autopre, .wr_bg, .wr_ba, .wr_col, .wr_data, .spacing_err);
  dws_link_monitor i_dws_link_monitor (.clk_sys, .reset, .mr0_bl(i_dws_link_if.mr0_bl),
    .al(i_dws_link_if.al), .cwl(i_dws_link_if.cwl), .pre2(i_dws_link_if.pre2),
    .cmd_wr(i_dws_link_if.cmd_wr), .bg(i_dws_link_if.bg), .addr(i_dws_link_if.addr),
    .dq_en(i_dws_link_if.dq_en));
  //////////////////////////////////////////////////
  task automatic summarize;
    if (bad_count == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [79:0] exp, input logic [79:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask
  task automatic guard(input int n);
    if (n >= 100) begin
      bad_count++;
      summarize();
    end
  endtask
  // Raised only once ready is seen, so the request is taken at the next edge.
  task automatic send(input logic [1:0] bg, input logic a12, input logic a10,
                      input logic [63:0] d);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 100) begin
      @(negedge clk_sys);
      n++;
    end
    guard(n);
    req_valid = 1'b1;
    req_bg = bg;
    req_ba = d[11:10];
    req_col = d[9:0];
    req_a12 = a12;
    req_a10 = a10;
    req_data = d;
    @(negedge clk_sys);
    req_valid = 1'b0;
  endtask
  task automatic expect_wr(input logic bc4, input logic a10, input logic [1:0] bg,
                           input logic [63:0] d);
    int n;
    n = 0;
    while (got_q.size() == 0 && n < 100) begin
      @(negedge clk_sys);
      n++;
    end
    guard(n);
    chk("record", {bc4, a10, bg, d[11:0], bc4 ? {32'h0, d[31:0]} : d}, got_q.pop_front());
    chk("latency", 80'(cfg_al + cfg_cwl + (bc4 ? 2 : 4)), 80'(lat_q.pop_front()));
  endtask
  task automatic run_pair(input logic [1:0] bl, input logic p2, input logic [1:0] bg2,
                          input logic a12a, input logic a12b, input int g);
    logic [63:0] d1;
    d1 = 64'h0123456789abcdef + 64'(n_checks);
    cfg_bl = bl;
    cfg_pre2 = p2;
    repeat (4) @(negedge clk_sys);
    send(2'h0, a12a, 1'b1, d1);
    send(bg2, a12b, 1'b0, ~d1);
    expect_wr(bl == BL_FIX4 || (bl == BL_OTF && !a12a), 1'b1, 2'h0, d1);
    expect_wr(bl == BL_FIX4 || (bl == BL_OTF && !a12b), 1'b0, bg2, ~d1);
    chk("spacing", 80'(g), 80'(gap));
    // Let the latency lines empty so a later latency change cannot replay old commands.
    repeat (DLY_DEPTH) @(negedge clk_sys);
  endtask
  //////////////////////////////////////////////////
  always @(negedge clk_sys) begin
    cyc++;
    if (i_dws_link_if.cmd_wr === 1'b1) begin
      gap = cyc - last;
      last = cyc;
      cmd_q.push_back(cyc);
    end
    if (wr_done === 1'b1) begin
      lat_q.push_back(cmd_q.size() > 0 ? cyc - cmd_q.pop_front() : -1);
      got_q.push_back({wr_bc4, wr_autopre, wr_bg, wr_ba, wr_col, wr_data});
    end
    if (!reset) begin
      chk("recov_start", 80'(wr_done && !i_dws_link_if.dq_en), 80'(recov_start));
    end
  end
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  initial begin
    reset = 1'b1;
    ce = 1'b1;
    cfg_bl = BL_FIX8;
    cfg_al = 5'h00;
    cfg_cwl = 5'h0a;
    cfg_pre2 = 1'b0;
    req_valid = 1'b0;
    req_bg = 2'h0;
    req_ba = 2'h0;
    req_col = 10'h000;
    req_a12 = 1'b0;
    req_a10 = 1'b0;
    req_data = 64'h0;
    repeat (16) @(negedge clk_sys);
    reset = 1'b0;
    run_pair(BL_FIX8, 1'b0, 2'h1, 1'b0, 1'b0, 4);
    run_pair(BL_OTF, 1'b0, 2'h2, 1'b1, 1'b0, 4);
    run_pair(BL_OTF, 1'b0, 2'h0, 1'b0, 1'b1, 5);
    run_pair(BL_FIX4, 1'b0, 2'h3, 1'b1, 1'b1, 4);
    cfg_al = 5'h03;
    run_pair(BL_OTF, 1'b0, 2'h1, 1'b1, 1'b1, 4);
    cfg_al = 5'h00;
    run_pair(BL_FIX8, 1'b1, 2'h0, 1'b1, 1'b1, 6);
    run_pair(BL_FIX8, 1'b1, 2'h2, 1'b1, 1'b1, 4);
    chk("spacing_err", 80'h0, 80'(spacing_err));
    // A nine-clock write latency with the long preamble must hold the write back.
    cfg_cwl = 5'h09;
    repeat (4) @(negedge clk_sys);
    chk("cfg_err", 80'h1, 80'(cfg_err));
    send(2'h1, 1'b1, 1'b0, 64'h5a5a0f0f3c3c9669);
    repeat (20) @(negedge clk_sys);
    chk("held", 80'h0, 80'(cmd_q.size()));
    // With the clock enable low a legal setting must not release the write yet.
    ce = 1'b0;
    cfg_cwl = 5'h0a;
    repeat (10) @(negedge clk_sys);
    chk("frozen", 80'h0, 80'(cmd_q.size()));
    ce = 1'b1;
    expect_wr(1'b0, 1'b0, 2'h1, 64'h5a5a0f0f3c3c9669);
    summarize();
  end
endmodule
`default_nettype wire
